// file: rtl/ccc_pkg.sv
// calendar clock control: shared constants, register map, field layout and types
// assumes a 25 MHz system clock and 32 kHz-class slow clocks sampled as plain inputs
package ccc_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  CONTROL_OFS     = 8'h00;  // calendar_control
  localparam logic [7:0]  TIME_OFS        = 8'h04;  // time_value

  // ----------------------------------------------------------------
  // calendar_control field positions
  // ----------------------------------------------------------------
  localparam int          OE_BIT          = 0;   // output_pin_enable
  localparam int          HALF_BIT        = 1;   // half_second_status
  localparam int          SYNC_BIT        = 2;   // read_sync_flag
  localparam int          WREN_BIT        = 3;   // value_write_enable
  localparam int          RUN_BIT         = 6;   // clock_running_status
  localparam int          OUTSEL_LO       = 7;   // output_source_select, 2 bits
  localparam int          CLKSEL_LO       = 9;   // clock_source_select, 2 bits
  localparam int          ON_BIT          = 15;  // calendar module enable
  localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // time_value field positions (bcd)
  // ----------------------------------------------------------------
  localparam int          SEC_LO          = 8;   // seconds 14:8
  localparam int          MIN_LO          = 16;  // minutes 22:16
  localparam int          HOUR_LO         = 24;  // hours 29:24
  localparam logic [31:0] TIME_WMASK      = 32'h3F7F_7F00;
  localparam logic [31:0] TIME_RESET      = 32'h0000_0000;
  localparam logic [7:0]  SEC_LAST        = 8'h59;
  localparam logic [7:0]  MIN_LAST        = 8'h59;
  localparam logic [7:0]  HOUR_LAST       = 8'h23;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          CLK_LOSS_NS     = 100000;  // no slow edge for this long: stopped
  localparam int          CLK_LOSS_CYC    = (CLK_LOSS_NS / CLK_PERIOD_NS < 1) ? 1 : CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int          PRESCALE_DIV    = 32768;   // slow edges per second
  localparam int          SYNC_WINDOW     = 16;      // slow edges before rollover flagged

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_LOW_POWER = 2'h0,
    SRC_CRYSTAL   = 2'h1
  } ccc_clk_src_type;

  typedef enum logic [1:0] {
    OUT_ALARM   = 2'h0,
    OUT_SECONDS = 2'h1,
    OUT_RAW     = 2'h2
  } ccc_out_sel_type;

  typedef enum logic [1:0] {
    MON_STOPPED = 2'b01,
    MON_RUNNING = 2'b10
  } ccc_mon_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ccc_bus_req_type;

endpackage

// file: rtl/ccc_prescaler.sv
// calendar clock control: slow-clock prescaler producing the one-second tick
// assumes step_i is a one-cycle pulse per slow clock edge, in the system clock domain
`timescale 1ns/1ns
module ccc_prescaler #(
  parameter int DIV = 32768
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // control
  input  wire logic                   step_i,
  input  wire logic                   clear_i,
  // state
  output logic [$clog2(DIV)-1:0]      count_o,
  output logic                        tick_o
);

  localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

  logic [$clog2(DIV)-1:0] count_r;
  logic [$clog2(DIV)-1:0] count_nxt;
  logic                   tick_r;
  logic                   wrap;

  // wrap on the last slow edge of a second
  assign wrap      = step_i && (count_r == LAST);
  assign count_nxt = clear_i ? '0 : (wrap ? '0 : (step_i ? count_r + 1'b1 : count_r));

  // counter and tick flops; a clear restarts the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= '0;
      tick_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r  <= wrap && !clear_i;
    end
  end

  assign count_o = count_r;
  assign tick_o  = tick_r;

endmodule

// file: rtl/ccc_top.sv
// calendar clock control: control register, time value register, clock source
// monitor, prescaler and output pin selection
// assumes slow clocks and alarm input are synchronous levels; reset_n_i is power-on reset
//
// How it works
// - clock select 01 picks crystal oscillator, 00 low-power oscillator; 10 and 11 reserved
// - output select 10 drives the selected slow clock onto the pin
// - output select 01 drives a once-per-second clock; 11 reserved
// - output select 00 pulses the pin on each alarm event
// - pin carries the selected signal only while output enable bit 0 is set
// - running status reads 1 while the module is enabled and the slow clock runs, else 0
// - time value writes take effect only while write enable is 1
// - write enable can be set only while system unlock is active
// - module enable bit writable only while write enable is 1
// - read sync flag is 1 while a rollover ripple may change values
// - half-second status is 0 in first half, 1 in second half
// - half-second status is read-only, cleared by a seconds write
// - control register resets only on power-on reset
// - control bits 5 and 4 always read zero
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
module ccc_top #(
  parameter int DIV       = ccc_pkg::PRESCALE_DIV,
  parameter int SYNC_WIN  = ccc_pkg::SYNC_WINDOW,
  parameter int LOSS_CYC  = ccc_pkg::CLK_LOSS_CYC
) (
  // clock and power-on reset
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  // register port
  input  wire ccc_pkg::ccc_bus_req_type    bus_req_i,
  output logic [ccc_pkg::DATA_W-1:0]       rdata_o,
  // slow clock sources and system inputs
  input  wire logic                        crystal_clk_i,
  input  wire logic                        low_power_clk_i,
  input  wire logic                        sys_unlock_i,
  input  wire logic                        alarm_event_i,
  // calendar output pin
  output logic                             cal_pin_o,
  output logic                             cal_pin_oe_o,
  // status to the system
  output logic                             module_on_o,
  output logic                             second_tick_o
);

  import ccc_pkg::*;

  localparam int                  CW        = $clog2(DIV);
  localparam logic [CW-1:0]       HALF_CNT  = CW'(DIV / 2);
  localparam logic [CW-1:0]       SYNC_CNT  = CW'(DIV - SYNC_WIN);
  localparam logic [15:0]         LOSS_LAST = 16'(LOSS_CYC - 1);

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  logic                    on_r;
  logic [1:0]              clksel_r;
  logic [1:0]              outsel_r;
  logic                    wren_r;
  logic                    oe_r;
  logic [DATA_W-1:0]       time_r;
  logic [DATA_W-1:0]       time_nxt;
  logic [DATA_W-1:0]       rdata_r;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire                     hit_ctrl   = (bus_req_i.addr == CONTROL_OFS);
  wire                     hit_time   = (bus_req_i.addr == TIME_OFS);
  wire                     wr_ctrl    = bus_req_i.wr && hit_ctrl;
  wire                     wr_time    = bus_req_i.wr && hit_time && wren_r;
  wire                     wr_seconds = wr_time;  // every accepted time write carries seconds

  // ----------------------------------------------------------------
  // slow clock source selection and sampling
  // ----------------------------------------------------------------
  logic                    src_level_r;
  logic                    src_prev_r;
  logic                    src_sel;
  logic                    src_valid;

  // reserved codes select no source, so the calendar stops
  assign src_valid = (clksel_r == SRC_CRYSTAL) || (clksel_r == SRC_LOW_POWER);
  assign src_sel   = (clksel_r == SRC_CRYSTAL)   ? crystal_clk_i :
                     (clksel_r == SRC_LOW_POWER) ? low_power_clk_i : 1'b0;

  // sample the selected source and keep one previous value for edges
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_level_r <= 1'b0;
      src_prev_r  <= 1'b0;
    end else begin
      src_level_r <= src_sel;
      src_prev_r  <= src_level_r;
    end
  end

  wire                     src_rise = src_level_r && !src_prev_r;

  // ----------------------------------------------------------------
  // clock monitor
  // ----------------------------------------------------------------
  ccc_mon_state_type       mon_state_r;
  ccc_mon_state_type       mon_state_nxt;
  logic [15:0]             loss_cnt_r;
  logic [15:0]             loss_cnt_nxt;
  wire                     loss_done = (loss_cnt_r == LOSS_LAST);

  // running once edges arrive, stopped after a long gap or on a bad code
  always_comb begin
    mon_state_nxt = mon_state_r;
    case (mon_state_r)
      MON_STOPPED: begin
        if (src_rise && src_valid) begin
          mon_state_nxt = MON_RUNNING;
        end
      end
      MON_RUNNING: begin
        if (!src_valid || (loss_done && !src_rise)) begin
          mon_state_nxt = MON_STOPPED;
        end
      end
      default: begin
        mon_state_nxt = MON_STOPPED;
      end
    endcase
  end

  // gap counter restarts on every slow edge and saturates at the limit
  assign loss_cnt_nxt = src_rise  ? 16'h0000 :
                        loss_done ? loss_cnt_r : loss_cnt_r + 16'h0001;

  // monitor flops
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mon_state_r <= MON_STOPPED;
      loss_cnt_r  <= 16'h0000;
    end else begin
      mon_state_r <= mon_state_nxt;
      loss_cnt_r  <= loss_cnt_nxt;
    end
  end

  wire                     clk_running = on_r && (mon_state_r == MON_RUNNING);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [CW-1:0]           pre_count;
  logic                    sec_tick;
  wire                     pre_step  = src_rise && src_valid && on_r;

  // divider from slow edges to seconds; a seconds write restarts it
  ccc_prescaler #(
    .DIV       (DIV)
  ) u_prescaler (
    .clk_i     (mclk_i),
    .reset_n_i (reset_n_i),
    .step_i    (pre_step),
    .clear_i   (wr_seconds),
    .count_o   (pre_count),
    .tick_o    (sec_tick)
  );

  // status flags from the same count
  wire                     half_sec  = (pre_count >= HALF_CNT);
  wire                     read_sync = on_r && ((pre_count >= SYNC_CNT) || sec_tick);

  // ----------------------------------------------------------------
  // time value: bcd seconds, minutes, hours with ripple carry
  // ----------------------------------------------------------------
  wire [7:0]               sec_v   = {1'b0, time_r[SEC_LO+6:SEC_LO]};
  wire [7:0]               min_v   = {1'b0, time_r[MIN_LO+6:MIN_LO]};
  wire [7:0]               hour_v  = {2'b00, time_r[HOUR_LO+5:HOUR_LO]};
  wire                     sec_wrap  = (sec_v == SEC_LAST);
  wire                     min_wrap  = (min_v == MIN_LAST);
  wire                     hour_wrap = (hour_v == HOUR_LAST);

  // bcd increment of one two-digit field
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  wire [7:0]               sec_n   = sec_wrap  ? 8'h00 : bcd_inc(sec_v);
  wire [7:0]               min_n   = min_wrap  ? 8'h00 : bcd_inc(min_v);
  wire [7:0]               hour_n  = hour_wrap ? 8'h00 : bcd_inc(hour_v);

  // advance on a tick, carrying upward; a software write wins
  always_comb begin
    time_nxt = time_r;
    if (wr_time) begin
      time_nxt = bus_req_i.wdata & TIME_WMASK;
    end else if (sec_tick) begin
      time_nxt[SEC_LO+6:SEC_LO] = sec_n[6:0];
      if (sec_wrap) begin
        time_nxt[MIN_LO+6:MIN_LO] = min_n[6:0];
        if (min_wrap) begin
          time_nxt[HOUR_LO+5:HOUR_LO] = hour_n[5:0];
        end
      end
    end
  end

  // time value flops
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      time_r <= TIME_RESET;
    end else begin
      time_r <= time_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  wire                     wd_wren = bus_req_i.wdata[WREN_BIT];
  wire                     wren_nxt = wr_ctrl ? (wd_wren && (wren_r || sys_unlock_i)) : wren_r;
  wire                     on_nxt   = (wr_ctrl && wren_r) ? bus_req_i.wdata[ON_BIT] : on_r;

  // control flops; only power-on reset clears them
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      on_r     <= CONTROL_RESET[ON_BIT];
      clksel_r <= CONTROL_RESET[CLKSEL_LO+1:CLKSEL_LO];
      outsel_r <= CONTROL_RESET[OUTSEL_LO+1:OUTSEL_LO];
      wren_r   <= CONTROL_RESET[WREN_BIT];
      oe_r     <= CONTROL_RESET[OE_BIT];
    end else begin
      on_r   <= on_nxt;
      wren_r <= wren_nxt;
      if (wr_ctrl) begin
        clksel_r <= bus_req_i.wdata[CLKSEL_LO+1:CLKSEL_LO];
        outsel_r <= bus_req_i.wdata[OUTSEL_LO+1:OUTSEL_LO];
        oe_r     <= bus_req_i.wdata[OE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]       ctrl_view;

  // status bits are live; unimplemented bits stay zero
  always_comb begin
    ctrl_view                          = '0;
    ctrl_view[ON_BIT]                  = on_r;
    ctrl_view[CLKSEL_LO+1:CLKSEL_LO]   = clksel_r;
    ctrl_view[OUTSEL_LO+1:OUTSEL_LO]   = outsel_r;
    ctrl_view[RUN_BIT]                 = clk_running;
    ctrl_view[WREN_BIT]                = wren_r;
    ctrl_view[SYNC_BIT]                = read_sync;
    ctrl_view[HALF_BIT]                = half_sec;
    ctrl_view[OE_BIT]                  = oe_r;
  end

  wire [DATA_W-1:0]        rd_mux = hit_ctrl ? ctrl_view :
                                    hit_time ? time_r : '0;  // unmapped reads zero

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= bus_req_i.rd ? rd_mux : '0;
    end
  end

  assign rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // output pin
  // ----------------------------------------------------------------
  logic                    alarm_pulse_r;
  logic                    pin_r;
  logic                    pin_oe_r;
  logic                    tick_out_r;
  logic                    pin_nxt;

  // pick the pin source by output select; reserved code drives low
  always_comb begin
    case (outsel_r)
      OUT_ALARM:   pin_nxt = alarm_pulse_r;
      OUT_SECONDS: pin_nxt = on_r && half_sec;
      OUT_RAW:     pin_nxt = on_r && src_valid && src_level_r;
      default:     pin_nxt = 1'b0;
    endcase
  end

  // pin flops; enable bit gates both level and drive
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alarm_pulse_r <= 1'b0;
      pin_r         <= 1'b0;
      pin_oe_r      <= 1'b0;
      tick_out_r    <= 1'b0;
    end else begin
      alarm_pulse_r <= alarm_event_i;
      pin_r         <= oe_r && pin_nxt;
      pin_oe_r      <= oe_r;
      tick_out_r    <= sec_tick;
    end
  end

  assign cal_pin_o     = pin_r;
  assign cal_pin_oe_o  = pin_oe_r;
  assign module_on_o   = on_r;
  assign second_tick_o = tick_out_r;

endmodule

// file: dv/ccc_top_asserts.sv
// calendar clock control: port-level checker, bound into ccc_top
// assumes one clock domain and the asynchronous power-on reset of the top module
`timescale 1ns/1ns
module ccc_top_asserts
  import ccc_pkg::*;
(
  // clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  // register port
  input  wire ccc_pkg::ccc_bus_req_type  bus_req_i,
  input  wire logic [ccc_pkg::DATA_W-1:0] rdata_o,
  // system inputs
  input  wire logic                      crystal_clk_i,
  input  wire logic                      low_power_clk_i,
  input  wire logic                      sys_unlock_i,
  input  wire logic                      alarm_event_i,
  // outputs
  input  wire logic                      cal_pin_o,
  input  wire logic                      cal_pin_oe_o,
  input  wire logic                      module_on_o,
  input  wire logic                      second_tick_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------
  // shadow of the writable control fields
  // ----------------------------------------------------------------
  logic [1:0] sel_sh;
  logic [2:0] quiet;
  logic       wren_sh;
  wire        ctl_wr = bus_req_i.wr && bus_req_i.addr == CONTROL_OFS;
  wire        ctl_rd = bus_req_i.rd && bus_req_i.addr == CONTROL_OFS;

  // quiet counts cycles since the last control write, saturating
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_sh  <= 2'h0;
      quiet   <= 3'h0;
      wren_sh <= 1'b0;
    end else if (ctl_wr) begin
      sel_sh  <= bus_req_i.wdata[OUTSEL_LO+:2];
      quiet   <= 3'h0;
      wren_sh <= bus_req_i.wdata[WREN_BIT] & (wren_sh | sys_unlock_i);
    end else if (quiet != 3'h7) begin
      quiet   <= quiet + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rd_zero;
    ctl_rd |=> rdata_o[14:11] == 4'h0 && rdata_o[5:4] == 2'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unused control bits read nonzero");
  property p_pin_gate;
    !cal_pin_oe_o |-> !cal_pin_o;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin high while output disabled");
  property p_oe_follow;
    ctl_wr |=> ##1 cal_pin_oe_o == $past(bus_req_i.wdata[OE_BIT], 2);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("output enable not following control bit");
  property p_on_locked;
    $changed(module_on_o) |-> $past(ctl_wr) && $past(wren_sh);
  endproperty
  a_on_locked: assert property (p_on_locked) else $error("module enable changed while locked");
  property p_wren;
    ctl_rd |=> rdata_o[WREN_BIT] == $past(wren_sh);
  endproperty
  a_wren: assert property (p_wren) else $error("write enable bit wrong");
  property p_tick_pulse;
    second_tick_o |=> !second_tick_o [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("second tick too long");
  property p_alarm_pin;
    cal_pin_oe_o && sel_sh == 2'h0 && quiet >= 3'h4 |-> cal_pin_o == $past(alarm_event_i, 2);
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pulse not on pin");
  property p_res_pin;
    cal_pin_oe_o && sel_sh == 2'h3 && quiet >= 3'h4 |-> !cal_pin_o;
  endproperty
  a_res_pin: assert property (p_res_pin) else $error("pin active in unused mode");
  property p_idle_run;
    ctl_rd && !module_on_o && !$past(module_on_o, 4) |=> !rdata_o[RUN_BIT];
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("running while disabled");
  property p_idle_sync;
    ctl_rd && !module_on_o && !$past(module_on_o, 4) |=> !rdata_o[SYNC_BIT];
  endproperty
  a_idle_sync: assert property (p_idle_sync) else $error("sync flag while disabled");
endmodule

bind ccc_top ccc_top_asserts u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i), .rdata_o(rdata_o),
  .crystal_clk_i(crystal_clk_i), .low_power_clk_i(low_power_clk_i), .sys_unlock_i(sys_unlock_i),
  .alarm_event_i(alarm_event_i), .cal_pin_o(cal_pin_o), .cal_pin_oe_o(cal_pin_oe_o),
  .module_on_o(module_on_o), .second_tick_o(second_tick_o)
);

// file: dv/ccc_tb_top.sv
// calendar clock control: self-checking testbench
// assumes short prescaler and monitor counts set at the instance
`timescale 1ns/1ns
module ccc_tb_top;
  import ccc_pkg::*;
  logic            mclk_i;
  logic            reset_n_i;
  ccc_bus_req_type req;
  logic [31:0]     rdata;
  logic            xtal, lp, xtal_run, lp_run, unlock, alarm;
  logic            pin, pin_oe, mod_on, tick;
  logic [3:0]      sdiv;
  int              num_errors = 0;
  int              compares = 0;

  ccc_top #(.DIV(64), .SYNC_WIN(4), .LOSS_CYC(50)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_req_i(req), .rdata_o(rdata),
    .crystal_clk_i(xtal), .low_power_clk_i(lp), .sys_unlock_i(unlock), .alarm_event_i(alarm),
    .cal_pin_o(pin), .cal_pin_oe_o(pin_oe), .module_on_o(mod_on), .second_tick_o(tick)
  );

  // clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // slow clocks: crystal period 8 cycles, low-power 12, stopped low when not running
  always @(posedge mclk_i) begin
    sdiv <= (sdiv == 4'hB) ? 4'h0 : sdiv + 4'h1;
    if (sdiv[1:0] == 2'h3) xtal <= xtal_run & ~xtal;
    if (sdiv == 4'h5 || sdiv == 4'hB) lp <= lp_run & ~lp;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    req <= '0;
    @(negedge mclk_i);
    v = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lock();
    logic [31:0] v;
    wr(CONTROL_OFS, 32'h0000_8039);
    rd(CONTROL_OFS, v);
    chk(v & 32'h0000_80B9, 32'h0000_0001);
    wr(TIME_OFS, 32'h0012_3400);
    rd(TIME_OFS, v);
    chk(v, 32'h0000_0000);
    @(posedge mclk_i);
    unlock <= 1'b1;
    wr(CONTROL_OFS, 32'h0000_0008);
    unlock <= 1'b0;
    rd(CONTROL_OFS, v);
    chk(v & 32'h0000_8009, 32'h0000_0008);
    wr(CONTROL_OFS, 32'h0000_8208);
    wr(TIME_OFS, 32'h0012_3400);
    rd(TIME_OFS, v);
    chk(v, 32'h0012_3400);
    chk({31'h0, mod_on}, 32'h1);
    wr(CONTROL_OFS, 32'h0000_8200);
    wr(CONTROL_OFS, 32'h0000_0200);
    wr(TIME_OFS, 32'h0000_0000);
    rd(TIME_OFS, v);
    chk(v, 32'h0012_3400);
    rd(CONTROL_OFS, v);
    chk(v & 32'h0000_8789, 32'h0000_8200);
  endtask

  task automatic t_clock();
    logic [31:0] v;
    cyc(100);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[RUN_BIT]}, 32'h1);
    wr(CONTROL_OFS, 32'h0000_8000);
    cyc(100);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[RUN_BIT]}, 32'h0);
    lp_run <= 1'b1;
    cyc(100);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[RUN_BIT]}, 32'h1);
    wr(CONTROL_OFS, 32'h0000_8400);
    cyc(10);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[RUN_BIT]}, 32'h0);
    wr(CONTROL_OFS, 32'h0000_8600);
    cyc(10);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[RUN_BIT]}, 32'h0);
  endtask

  task automatic t_second();
    logic [31:0] v;
    int          n;
    @(posedge mclk_i);
    unlock <= 1'b1;
    wr(CONTROL_OFS, 32'h0000_8208);
    unlock <= 1'b0;
    wr(TIME_OFS, 32'h0000_5900);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[HALF_BIT]}, 32'h0);
    cyc(320);
    rd(CONTROL_OFS, v);
    chk({30'h0, v[SYNC_BIT], v[HALF_BIT]}, 32'h1);
    n = 0;
    do begin
      rd(CONTROL_OFS, v);
      n++;
    end while (v[SYNC_BIT] !== 1'b1 && n < 100);
    chk({31'h0, v[SYNC_BIT]}, 32'h1);
    n = 0;
    while (tick !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    chk({31'h0, tick}, 32'h1);
    rd(TIME_OFS, v);
    chk(v, 32'h0001_0000);
    rd(TIME_OFS, v);
    chk(v, 32'h0001_0000);
  endtask

  task automatic t_pin();
    logic [31:0] v;
    int          n;
    wr(CONTROL_OFS, 32'h0000_8308);
    cyc(10);
    chk({30'h0, pin_oe, pin}, 32'h0);
    wr(CONTROL_OFS, 32'h0000_8309);
    cyc(10);
    n = 0;
    repeat (32) begin
      @(negedge mclk_i);
      if (pin === 1'b1) n++;
    end
    chk(32'(n), 32'h10);
    chk({31'h0, pin_oe}, 32'h1);
    wr(CONTROL_OFS, 32'h0000_8289);
    wr(TIME_OFS, 32'h0000_0000);
    cyc(100);
    chk({31'h0, pin}, 32'h0);
    cyc(200);
    chk({31'h0, pin}, 32'h1);
    wr(TIME_OFS, 32'h0000_0000);
    rd(CONTROL_OFS, v);
    chk({31'h0, v[HALF_BIT]}, 32'h0);
    wr(CONTROL_OFS, 32'h0000_8389);
    cyc(10);
    chk({31'h0, pin}, 32'h0);
    wr(CONTROL_OFS, 32'h0000_8209);
    cyc(5);
    @(posedge mclk_i);
    alarm <= 1'b1;
    @(posedge mclk_i);
    alarm <= 1'b0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    v[0] = pin;
    @(negedge mclk_i);
    v[1] = pin;
    chk({30'h0, v[1:0]}, 32'h1);
  endtask

  task automatic t_por();
    logic [31:0] v;
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(CONTROL_OFS, v);
    chk(v, CONTROL_RESET);
    rd(8'h10, v);
    chk(v, 32'h0000_0000);
    chk({31'h0, mod_on}, 32'h0);
  endtask

  // main sequence
  initial begin
    reset_n_i = 1'b0;
    req = '0;
    xtal = 1'b0;
    lp = 1'b0;
    sdiv = 4'h0;
    xtal_run = 1'b1;
    lp_run = 1'b0;
    unlock = 1'b0;
    alarm = 1'b0;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_lock();
    t_clock();
    t_second();
    t_pin();
    t_por();
    summarize();
  end

  // watchdog, several times the expected run length
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    summarize();
  end
endmodule
